// *** bench/spi_host_model.sv ***
// Host model: SPI master in any of the four clock modes.
// Assumes the bench selects only after the port reports ready.
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  input  wire logic cpol,
  input  wire logic cpha,
  input  wire logic miso,
  output var  logic sck,
  output var  logic ss_n,
  output var  logic mosi
);
  initial begin
    sck = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end
  // Released data line toggles so a stale level is never trusted
  task sel(input on);
    // Clock settles to idle first, so no false edge meets the select
    sck = cpol;
    #400;
    ss_n = ~on;
    if (!on)
      mosi = ~mosi;
    #400;
  endtask
  task automatic xfer(input [7:0] tx, output [7:0] rx);
    integer i;
    for (i = 7; i >= 0; i = i - 1) begin
      if (cpha) begin
        sck = ~cpol;
        mosi = tx[i];
        #400;
        sck = cpol;
        rx[i] = miso;
        #400;
      end else begin
        mosi = tx[i];
        #400;
        sck = ~cpol;
        rx[i] = miso;
        #400;
        sck = cpol;
      end
    end
    #2000;
  endtask
endmodule // spi_host_model
`default_nettype wire

// *** bench/spi_port_props.sv ***
// Checker: timing relations at the SPI slave port pins.
// Bound to every spi_slave_port instance; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module spi_port_props (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       slave_select_0_n,
  input wire logic       miso_oe,
  input wire logic       ready_out_n,
  input wire logic       spi_slave_mode,
  input wire logic       main_port_enable,
  input wire logic [7:0] rx_data,
  input wire logic       rx_valid,
  input wire logic       rx_ready,
  input wire logic       tx_valid,
  input wire logic       tx_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  mode_hold_a: assert property
    (!ready_out_n |-> $stable(spi_slave_mode)) else $error("mode moved");
  port_off_a: assert property
    (!ready_out_n |-> main_port_enable == !spi_slave_mode)
    else $error("main port not off");
  ready_hold_a: assert property
    (!ready_out_n |=> !ready_out_n) else $error("ready dropped");
  oe_wait_a: assert property
    (ready_out_n |-> !miso_oe) else $error("miso driven before ready");
  // Four samples cover the select synchroniser latency
  oe_idle_a: assert property
    (slave_select_0_n [*4] |-> !miso_oe) else $error("miso driven idle");
  rx_nonzero_a: assert property
    (rx_valid |-> rx_data != 8'h00) else $error("zero byte passed");
  rx_hold_a: assert property
    (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("stalled byte lost");
  tx_pulse_a: assert property
    (tx_ready |=> !tx_ready) else $error("take pulse too long");
  tx_take_a: assert property
    (tx_ready |-> tx_valid) else $error("took absent byte");
  cover property (rx_valid && rx_ready);
  cover property (rx_valid && !rx_ready);
  cover property (tx_ready);
  cover property ($fell(ready_out_n));
endmodule // spi_port_props
bind spi_slave_port spi_port_props chk (.clk(clk), .rst(rst),
  .slave_select_0_n(slave_select_0_n), .miso_oe(miso_oe),
  .ready_out_n(ready_out_n), .spi_slave_mode(spi_slave_mode),
  .main_port_enable(main_port_enable), .rx_data(rx_data),
  .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_valid(tx_valid),
  .tx_ready(tx_ready));
`default_nettype wire

// *** bench/tb_spi_slave_port.sv ***
// Bench for the SPI slave port: modes, data, status, full buffer.
// Assumes the host model drives the SPI pins from bench tasks.
`timescale 1ns/100ps
`default_nettype none
module tb_spi_slave_port;
  logic        clk = 0, rst = 1, pol = 0, pha = 0, cs_c = 0, want = 0;
  logic        pal = 0, loc = 0, ext = 0, rx_ready = 1, tx_valid = 0;
  logic        m_pol = 0, m_pha = 0, sb = 1, sd = 1;
  wire         oe;
  logic [7:0]  tx_data = 8'h00, stat = 8'h00, rq[$], tq[$], hq[$];
  logic [15:0] space = 16'h0383;
  wire         sck, ss_n, mosi, miso, rdy_n, mode, mpe, rx_valid, tx_ready;
  wire  [7:0]  rx_data;
  integer      err_total = 0, checks = 0, m;
  always #50 clk = ~clk;
  spi_host_model host (.cpol(m_pol), .cpha(m_pha), .miso(miso),
    .sck(sck), .ss_n(ss_n), .mosi(mosi));
  spi_slave_port dut (.clk(clk), .rst(rst), .strap_clock_in(sck),
    .config_strap_b(sb), .config_strap_c(cs_c), .config_strap_d(sd),
    .polarity_strap(pol), .phase_strap(pha), .slave_select_0_n(ss_n),
    .mosi(mosi), .miso(miso), .miso_oe(oe), .ready_out_n(rdy_n),
    .spi_slave_mode(mode), .main_port_enable(mpe), .video_pal(pal),
    .video_local(loc), .ext_video_present(ext), .rx_space_free(space),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
  always @(negedge clk) begin
    tx_valid <= tq.size() > 0;
    if (tq.size() > 0)
      tx_data <= tq[0];
  end
  always @(posedge clk) begin
    if (tx_ready === 1'b1)
      void'(tq.pop_front());
    if (rx_valid === 1'b1 && rx_ready === 1'b1)
      rq.push_back(rx_data);
  end
  task chk(input [7:0] got, input [7:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Host receive side: zeros skipped, byte after a marker is status
  task xb(input [7:0] b);
    logic [7:0] r;
    host.xfer(b, r);
    if (want) begin
      stat = r;
      want = 1'b0;
    end else if (r == 8'hff)
      want = 1'b1;
    else if (r != 8'h00)
      hq.push_back(r);
  endtask
  task t_init(input [1:0] md);
    integer i;
    {sb, sd} = 2'b11;
    {pol, pha, m_pol, m_pha, cs_c, rst} = {md, md, 2'b01};
    repeat (12) @(negedge clk);
    rst = 1'b0;
    for (i = 0; i < 3000 && rdy_n !== 1'b0; i = i + 1)
      @(negedge clk);
    chk({7'h00, rdy_n}, 8'h00);
    if (rdy_n !== 1'b0)
      conclude;
    {pol, pha, cs_c} = {~md, 1'b1};
    repeat (4) @(negedge clk);
    chk({6'h00, mode, mpe}, 8'h02);
    chk({7'h00, oe}, 8'h00);
    $display("init mode %0d done", md);
  endtask
  // Straps not selecting slave: no ready, main port stays on
  task t_noslave(input b, input d);
    {sb, sd, rst} = {b, d, 1'b1};
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (1100) @(negedge clk);
    chk({5'h00, rdy_n, mode, mpe}, 8'h05);
    chk({7'h00, oe}, 8'h00);
    $display("no slave done");
  endtask
  // Status cuts into queued transmit bytes, which then resume
  task t_stat(input [1:0] md, input [15:0] sp, input [3:0] n);
    {pal, loc, ext, space, stat} = {md[0], md[1], ~md[0], sp, 8'h00};
    hq.delete();
    tq = '{8'hc2, 8'h37};
    host.sel(1'b1);
    xb(8'hff);
    repeat (5) xb(8'h00);
    host.sel(1'b0);
    chk(stat, {1'b0, pal, loc, ext, n});
    chk(8'(hq.size()), 8'h02);
    chk(hq[0], 8'hc2);
    chk(hq[1], 8'h37);
    $display("status mode %0d done", md);
  endtask
  task t_rx;
    rq.delete();
    host.sel(1'b1);
    xb(8'h41);
    xb(8'h00);
    xb(8'h42);
    host.sel(1'b0);
    repeat (4) @(negedge clk);
    chk(8'(rq.size()), 8'h02);
    chk(rq[0], 8'h41);
    chk(rq[1], 8'h42);
    $display("receive done");
  endtask
  // Consumer stalls; the third byte finds the buffer full
  task t_full;
    rq.delete();
    rx_ready = 1'b0;
    host.sel(1'b1);
    xb(8'h51);
    xb(8'h52);
    xb(8'h53);
    host.sel(1'b0);
    rx_ready = 1'b1;
    repeat (4) @(negedge clk);
    chk(8'(rq.size()), 8'h02);
    chk(rq[0], 8'h51);
    chk(rq[1], 8'h52);
    $display("full buffer done");
  endtask
  initial begin
    @(negedge clk);
    t_noslave(1'b0, 1'b1);
    t_noslave(1'b1, 1'b0);
    for (m = 0; m < 4; m = m + 1) begin
      t_init(m[1:0]);
      case (m)
        0: t_stat(2'd0, 16'h0383, 4'h9);
        1: t_stat(2'd1, 16'h0001, 4'h0);
        2: t_stat(2'd2, 16'h0002, 4'h1);
        default: t_stat(2'd3, 16'h8000, 4'hf);
      endcase
    end
    t_rx;
    t_full;
    conclude;
  end
endmodule // tb_spi_slave_port
`default_nettype wire

// *** hdl/byte_buffer2.v ***
// Two-entry byte buffer with valid/ready on both sides.
// Assumes one clock domain shared with producer and consumer.
`timescale 1ns/100ps
`default_nettype none
module byte_buffer2 (
  input  wire       clk,
  input  wire       rst,
  input  wire [7:0] in_data,
  input  wire       in_valid,
  output wire       in_ready,
  output wire [7:0] out_data,
  output wire       out_valid,
  input  wire       out_ready
);
  reg [7:0] mem [0:1];
  reg       wr_ptr;
  reg       rd_ptr;
  reg [1:0] count;
  wire      push;
  wire      pop;

  assign in_ready  = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk) begin
    if (rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'd0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
      if (push & ~pop)
        count <= count + 2'd1;
      else if (pop & ~push)
        count <= count - 2'd1;
    end
  end
endmodule // byte_buffer2
`default_nettype wire

// *** hdl/spi_slave_port.v ***
// SPI slave command port: strap capture, byte shifter, status reports.
// Assumes SPI pins are asynchronous to clk and much slower than it.
//
// Function
// - Slave mode when straps b and d high, c low; clock on strap pin.
// - Slave mode selected disables the main asynchronous serial port.
// - Polarity and phase straps pick one of four SPI clock modes.
// - Polarity/phase straps sampled every cycle of the wait after config straps, then ignored.
// - All straps sampled only at initialization.
// - Select may stay active indefinitely; alignment by bit counting only (select high also clears the bit count here).
// - Ready output driven low after initialization in slave mode only, no other function.
// - Full duplex: one byte out for every byte in.
// - Received zero bytes are discarded.
// - Received 0xFF answered with 0xFF then status byte.
// - Status bits: 7 zero, 6 PAL, 5 local mode, 4 external video.
// - Low nibble n: at least two to the n bytes free.
// - Bytes arriving with receive buffer full are dropped silently.
// - Status may interrupt the queue, which then resumes.
`timescale 1ns/100ps
`default_nettype none
`include "spi_slave_port_regs.vh"
module spi_slave_port (
  input  wire                   clk,
  input  wire                   rst,
  input  wire                   strap_clock_in,
  input  wire                   config_strap_b,
  input  wire                   config_strap_c,
  input  wire                   config_strap_d,
  input  wire                   polarity_strap,
  input  wire                   phase_strap,
  input  wire                   slave_select_0_n,
  input  wire                   mosi,
  output reg                    miso,
  output reg                    miso_oe,
  output reg                    ready_out_n,
  output reg                    spi_slave_mode,
  output reg                    main_port_enable,
  input  wire                   video_pal,
  input  wire                   video_local,
  input  wire                   ext_video_present,
  input  wire [`RX_SPACE_W-1:0] rx_space_free,
  output wire [7:0]             rx_data,
  output wire                   rx_valid,
  input  wire                   rx_ready,
  input  wire [7:0]             tx_data,
  input  wire                   tx_valid,
  output reg                    tx_ready
);
  localparam ST_RESET   = 2'd0;
  localparam ST_CONFIG  = 2'd1;
  localparam ST_MODE    = 2'd2;
  localparam ST_RUN     = 2'd3;

  reg [1:0]  state;
  reg [`INIT_CNT_W-1:0] init_cnt;
  reg        cpol;
  reg        cpha;
  reg [1:0]  sck_s;
  reg [1:0]  ss_s;
  reg [1:0]  mosi_s;
  reg        sck_prev;
  reg [7:0]  rx_shift;
  reg [7:0]  tx_shift;
  reg [2:0]  bit_cnt;
  reg        stat_pending;
  reg        mark_due;
  reg        preload;
  reg        pre_take;
  reg        pre_stat;
  reg        pre_mark;
  reg        next_mark;
  reg        in_valid;
  reg [7:0]  in_data;
  wire       in_ready;
  wire       sck;
  wire       ss_active;
  wire       lead_edge;
  wire       trail_edge;
  wire       sample_edge;
  wire       shift_edge;
  wire [7:0] rx_byte;
  reg  [3:0] space_n;
  reg  [7:0] next_tx;
  reg        take_tx;
  reg        next_stat;
  integer    i;

  // Bring slave pins into clk domain
  always @(posedge clk) begin
    sck_s  <= {sck_s[0], strap_clock_in};
    ss_s   <= {ss_s[0], slave_select_0_n};
    mosi_s <= {mosi_s[0], mosi};
  end
  assign sck       = sck_s[1] ^ cpol;
  assign ss_active = ~ss_s[1] & (state == ST_RUN) & spi_slave_mode;
  assign lead_edge  = sck & ~sck_prev;
  assign trail_edge = ~sck & sck_prev;
  assign sample_edge = cpha ? trail_edge : lead_edge;
  assign shift_edge  = cpha ? lead_edge : trail_edge;
  assign rx_byte    = {rx_shift[6:0], mosi_s[1]};

  // Strap capture; wait models initialization before ready
  always @(posedge clk) begin
    if (rst) begin
      state            <= ST_RESET;
      init_cnt         <= {`INIT_CNT_W{1'b0}};
      spi_slave_mode   <= 1'b0;
      main_port_enable <= 1'b0;
      cpol             <= 1'b0;
      cpha             <= 1'b0;
      ready_out_n      <= 1'b1;
    end else begin
      case (state)
        ST_RESET: state <= ST_CONFIG;
        ST_CONFIG: begin
          spi_slave_mode   <= config_strap_b & ~config_strap_c
                              & config_strap_d;
          main_port_enable <= ~(config_strap_b & ~config_strap_c
                              & config_strap_d);
          state            <= ST_MODE;
        end
        ST_MODE: begin
          cpol  <= polarity_strap;
          cpha  <= phase_strap;
          if (init_cnt == `INIT_CYCLES - 1)
            state <= ST_RUN;
          else
            init_cnt <= init_cnt + 1'b1;
        end
        ST_RUN: ready_out_n <= ~spi_slave_mode;
        default: state <= ST_RESET;
      endcase
    end
  end

  // Free-space exponent: highest set bit of the free count
  always @* begin
    space_n = 4'd0;
    for (i = 1; i < `RX_SPACE_W; i = i + 1)
      if (rx_space_free[i])
        space_n = i[3:0];
  end

  // Choice of next outgoing byte; marker then status preempt the queue
  always @* begin
    take_tx   = 1'b0;
    next_stat = stat_pending;
    next_mark = mark_due;
    if (mark_due) begin
      next_tx   = `STATUS_REQ_CODE;
      next_mark = 1'b0;
    end else if (stat_pending) begin
      next_tx   = {1'b0, video_pal, video_local, ext_video_present,
                   space_n};
      next_stat = 1'b0;
    end else if (tx_valid) begin
      next_tx = tx_data;
      take_tx = 1'b1;
    end else begin
      next_tx = `NULL_CODE;
    end
  end

  // Bit engine; select high resets alignment
  always @(posedge clk) begin
    if (rst) begin
      sck_prev     <= 1'b0;
      rx_shift     <= 8'h00;
      tx_shift     <= 8'h00;
      bit_cnt      <= 3'd0;
      stat_pending <= 1'b0;
      mark_due     <= 1'b0;
      preload      <= 1'b0;
      pre_take     <= 1'b0;
      pre_stat     <= 1'b0;
      pre_mark     <= 1'b0;
      in_valid     <= 1'b0;
      in_data      <= 8'h00;
      miso         <= 1'b0;
      miso_oe      <= 1'b0;
      tx_ready     <= 1'b0;
    end else begin
      sck_prev <= sck;
      tx_ready <= 1'b0;
      miso_oe  <= ss_active;
      if (in_valid & in_ready)
        in_valid <= 1'b0;
      if (~ss_active) begin
        bit_cnt  <= 3'd0;
        // Idle preview only; in mode 0/2 consumed once the first bit is sampled, unused in mode 1/3
        preload  <= ~cpha;
        pre_take <= take_tx;
        pre_stat <= next_stat;
        pre_mark <= next_mark;
        if (!cpha) begin
          miso     <= next_tx[7];
          tx_shift <= {next_tx[6:0], 1'b0};
        end
      end else begin
        if (sample_edge) begin
          rx_shift <= rx_byte;
          bit_cnt  <= bit_cnt + 3'd1;
          if (preload) begin
            preload      <= 1'b0;
            tx_ready     <= pre_take;
            stat_pending <= pre_stat;
            mark_due     <= pre_mark;
          end
          if (bit_cnt == 3'd7) begin
            // Full buffer or zero: byte is dropped
            if (rx_byte != `NULL_CODE && in_ready) begin
              in_valid <= 1'b1;
              in_data  <= rx_byte;
            end
            if (rx_byte == `STATUS_REQ_CODE && !stat_pending
                && !mark_due) begin
              stat_pending <= 1'b1;
              // Queue head stays put so it resumes after status
              if (!cpha)
                tx_shift <= `STATUS_REQ_CODE;
              else
                mark_due <= 1'b1;
            end else if (!cpha) begin
              tx_shift     <= next_tx;
              tx_ready     <= take_tx;
              stat_pending <= next_stat;
              mark_due     <= next_mark;
            end
          end
        end
        if (shift_edge) begin
          if (cpha && bit_cnt == 3'd0) begin
            miso         <= next_tx[7];
            tx_shift     <= {next_tx[6:0], 1'b0};
            tx_ready     <= take_tx;
            stat_pending <= next_stat;
            mark_due     <= next_mark;
          end else begin
            miso     <= tx_shift[7];
            tx_shift <= {tx_shift[6:0], 1'b0};
          end
        end
      end
    end
  end

  // Mode 1/3 sends the 0xFF marker on the next byte via mark_due
  // Mode 0/2 reloads at the last sample, so the marker follows at once

  byte_buffer2 rx_buf (
    .clk       (clk),
    .rst       (rst),
    .in_data   (in_data),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .out_data  (rx_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );
endmodule // spi_slave_port
`default_nettype wire

// *** hdl/spi_slave_port_regs.vh ***
// Constants for the SPI slave command port: codes, fields, timing.
// Assumes a 10 MHz system clock; included by bare name.
`ifndef SPI_SLAVE_PORT_REGS_VH
`define SPI_SLAVE_PORT_REGS_VH
`define STATUS_REQ_CODE     8'hff
`define NULL_CODE           8'h00
`define STAT_RSVD_BIT       7
`define STAT_PAL_BIT        6
`define STAT_LOCAL_BIT      5
`define STAT_EXTVID_BIT     4
`define STAT_SPACE_MSB      3
`define RX_SPACE_W          16
`define INIT_TIME_US        100
`define CLK_MHZ             10
`define INIT_CYCLES         (`INIT_TIME_US * `CLK_MHZ)
`define INIT_CNT_W          12
`endif
